// ---- shared/usb_irq_map.svh ----
// Register map, field positions, reset values and timing counts of the USB flag block
`ifndef USB_IRQ_MAP_SVH
`define USB_IRQ_MAP_SVH

// ============================================================
// Register addresses (byte addresses, one 32-bit word each)
`define REG_ADDR_W 8
`define REG_EVENT_FLAGS 8'h00
`define REG_EVENT_ENABLES 8'h04
`define REG_ERROR_FLAGS 8'h08
`define REG_ERROR_ENABLES 8'h0C
`define REG_XFER_STATUS 8'h10
`define REG_CONTROL 8'h14

// ============================================================
// Event flag bit positions
`define EV_BUS_RESET 0
`define EV_ERROR_SUMMARY 1
`define EV_FRAME_START 2
`define EV_TOKEN_DONE 3
`define EV_IDLE_DETECT 4
`define EV_RESUME 5
`define EV_ATTACH 6
`define EV_STALL 7

// ============================================================
// Error flag bit positions
`define ER_PACKET_ID 0
`define ER_CRC5_OR_EOF 1
`define ER_DATA_CRC 2
`define ER_PARTIAL_BYTE 3
`define ER_TURNAROUND 4
`define ER_MEMORY_ACCESS 5
`define ER_BUS_ADDRESS 6
`define ER_STUFF 7

// ============================================================
// Control register fields and reset values
`define CTL_HOST_MODE 0
`define FLAGS_RESET 8'h00
`define ENABLES_RESET 8'h00
`define CONTROL_RESET 1'h0

// ============================================================
// Timing
`define CLK_FREQ_MHZ 200
`define ATTACH_IDLE_TIME_NS 2500
`define RESUME_K_TIME_NS 2500
`define IDLE_DETECT_TIME_MS 3
`define TURNAROUND_LIMIT_BITS 16
`define ATTACH_CYCLES ((`ATTACH_IDLE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RESUME_CYCLES ((`RESUME_K_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define IDLE_CYCLES (`IDLE_DETECT_TIME_MS * 1000 * `CLK_FREQ_MHZ)

`endif

// ---- shared/usb_irq_pkg.sv ----
// Types shared by the USB interrupt and error flag block
`default_nettype none
package usb_irq_pkg;
	// One entry of the transfer status FIFO
	typedef struct packed {
		logic [3:0] endpoint;
		logic tx_dir;
		logic odd_bank;
	} xfer_status_s;

	// Turnaround watchdog states
	typedef enum logic [0:0] {
		TA_IDLE,
		TA_WAIT
	} ta_state_e;
endpackage
`default_nettype wire

// ---- hdl/usb_interrupt_error_flags.sv ----
// USB event flags, error flags, enables, transfer status FIFO and interrupt request
// How it works
// - Stall pulse from the engine sets the stall flag in either mode.
// - Host mode, bus quiet and not SE0 for 2.5 us sets attach flag.
// - K state held 2.5 us on the data lines sets the resume flag.
// - Bus idle continuously for 3 ms sets the idle detect flag.
// - Token done flag sets when a token finishes; status word holds its endpoint.
// - Software clearing token done pops the transfer status FIFO.
// - Status word is head of a four-entry FIFO, valid only while flag set.
// - Frame start flag: received token in device mode, threshold in host mode.
// - Error summary reflects only enabled error flags and is read-only.
// - Device mode: event bit 0 is bus reset, set on valid bus reset.
// - Host mode: event bit 0 is detach, set on peripheral detach.
// - Eight read/write event enables, zero at reset; bit 0 follows mode.
// - Errors reach the interrupt only while the summary enable is set.
// - Bits 31 to 8 of all flag registers read zero.
// - Error flags are hardware set, write-one-clear, zero at reset.
// - Bit stuff violation sets the stuff error flag.
// - Invalid descriptor table or buffer address sets bus address error.
// - Late bus grant or truncated packet sets memory access error.
// - More than 16 bit-times idle after EOP without response sets timeout.
// - Data field not whole bytes sets the partial byte flag.
// - Data CRC16 failure sets the data CRC error flag.
// - Host mode: error bit 1 sets when busy as frame counter hits zero.
// - Device mode: error bit 1 sets on token CRC5 failure.
// - Packet identifier check failure sets error bit 0.
`timescale 1ns/100ps
`default_nettype none
`include "usb_irq_map.svh"

module usb_interrupt_error_flags #(
	parameter int FIFO_DEPTH = 4,
	parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [`REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wr_data_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rd_data_out,
	// Bus line state
	input wire logic bus_active_in,
	input wire logic bus_se0_in,
	input wire logic bus_kstate_in,
	input wire logic bus_idle_in,
	input wire logic bit_tick_in,
	// Transaction engine events
	input wire logic stall_handshake_in,
	input wire logic token_done_in,
	input wire usb_irq_pkg::xfer_status_s token_status_in,
	input wire logic sof_token_in,
	input wire logic sof_threshold_in,
	input wire logic bus_reset_in,
	input wire logic detach_in,
	input wire logic eop_in,
	input wire logic await_response_in,
	input wire logic response_start_in,
	input wire logic sof_count_zero_in,
	input wire logic link_busy_in,
	// Error events
	input wire logic stuff_error_in,
	input wire logic bus_address_error_in,
	input wire logic memory_access_error_in,
	input wire logic partial_byte_in,
	input wire logic data_crc_error_in,
	input wire logic token_crc_error_in,
	input wire logic packet_id_error_in,
	// Status and interrupt
	output logic status_fifo_full_out,
	output logic host_mode_enable_out,
	output logic module_interrupt_request_out
);
	import usb_irq_pkg::*;

	// ============================================================
	// Elaboration checks
	localparam int ATT_CYC = `ATTACH_CYCLES;
	localparam int RES_CYC = `RESUME_CYCLES;
	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam int ATT_W = $clog2(ATT_CYC + 1);
	localparam int RES_W = $clog2(RES_CYC + 1);
	localparam int IDL_W = $clog2(IDLE_CYCLES + 1);
	localparam int TA_W = $clog2(`TURNAROUND_LIMIT_BITS + 1);

	// Pointer wrap relies on a power-of-two depth
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
		$error("FIFO_DEPTH must be a power of two, at least 2");
	end
	// Parked timers compare against the limit minus one
	if (IDLE_CYCLES < 2) begin
		$error("IDLE_CYCLES must be at least 2");
	end
	if (ATT_CYC < 2 || RES_CYC < 2) begin
		$error("attach and resume times must span at least 2 cycles");
	end
	if (`REG_ADDR_W < 5) begin
		$error("register address too narrow for the map");
	end

	// ============================================================
	// State
	typedef struct packed {
		logic [7:0] ev_flag;
		logic [7:0] ev_en;
		logic [7:0] err_flag;
		logic [7:0] err_en;
		logic host_en;
		logic [31:0] rd_data;
		logic attached;
		logic [ATT_W-1:0] att_cnt;
		logic [RES_W-1:0] res_cnt;
		logic [IDL_W-1:0] idle_cnt;
		ta_state_e ta_state;
		logic [TA_W-1:0] ta_cnt;
		xfer_status_s [FIFO_DEPTH-1:0] fifo;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] fill;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// ============================================================
	// Derived views
	logic fifo_empty;
	logic fifo_full;
	logic token_done_flag;
	logic error_summary_flag;
	logic [7:0] ev_view;
	xfer_status_s head;

	assign fifo_empty = (st_r.fill == '0);
	assign fifo_full = (st_r.fill == CNT_W'(FIFO_DEPTH));
	assign token_done_flag = !fifo_empty;
	assign error_summary_flag = |(st_r.err_flag & st_r.err_en);
	assign head = st_r.fifo[st_r.rd_ptr];

	// Token done and summary are live views, never stored
	always_comb begin
		ev_view = st_r.ev_flag;
		ev_view[`EV_TOKEN_DONE] = token_done_flag;
		ev_view[`EV_ERROR_SUMMARY] = error_summary_flag;
	end

	// ============================================================
	// Next state
	logic wr_ev;
	logic wr_err;
	logic pop;
	logic push;
	logic [7:0] ev_set;
	logic [7:0] err_set;
	logic [7:0] ev_clr;
	logic [7:0] err_clr;
	logic att_ok;

	always_comb begin
		st_nxt = st_r;
		wr_ev = reg_wr_in && (reg_addr_in == `REG_EVENT_FLAGS);
		wr_err = reg_wr_in && (reg_addr_in == `REG_ERROR_FLAGS);
		ev_set = 8'h00;
		err_set = 8'h00;

		// Event sources; bit 0 and the frame start source follow the mode
		ev_set[`EV_STALL] = stall_handshake_in;
		if (st_r.host_en) begin
			ev_set[`EV_FRAME_START] = sof_threshold_in;
			ev_set[`EV_BUS_RESET] = detach_in;
		end else begin
			ev_set[`EV_FRAME_START] = sof_token_in;
			ev_set[`EV_BUS_RESET] = bus_reset_in;
		end

		// Attach: quiet, non-SE0 bus in host mode, once per attachment
		att_ok = st_r.host_en && !bus_active_in && !bus_se0_in && !st_r.attached;
		if (!att_ok) begin
			st_nxt.att_cnt = '0;
		end else if (st_r.att_cnt == ATT_W'(ATT_CYC - 1)) begin
			ev_set[`EV_ATTACH] = 1'b1;
			st_nxt.attached = 1'b1;
			st_nxt.att_cnt = '0;
		end else begin
			st_nxt.att_cnt = st_r.att_cnt + 1'b1;
		end
		if (!st_r.host_en || detach_in) begin
			st_nxt.attached = 1'b0;
		end

		// Resume: counter parks at the limit so a long K fires once
		if (!bus_kstate_in) begin
			st_nxt.res_cnt = '0;
		end else if (st_r.res_cnt == RES_W'(RES_CYC - 1)) begin
			ev_set[`EV_RESUME] = 1'b1;
			st_nxt.res_cnt = RES_W'(RES_CYC);
		end else if (st_r.res_cnt != RES_W'(RES_CYC)) begin
			st_nxt.res_cnt = st_r.res_cnt + 1'b1;
		end

		// Idle detect, same parking scheme
		if (!bus_idle_in) begin
			st_nxt.idle_cnt = '0;
		end else if (st_r.idle_cnt == IDL_W'(IDLE_CYCLES - 1)) begin
			ev_set[`EV_IDLE_DETECT] = 1'b1;
			st_nxt.idle_cnt = IDL_W'(IDLE_CYCLES);
		end else if (st_r.idle_cnt != IDL_W'(IDLE_CYCLES)) begin
			st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
		end

		// Turnaround watchdog, counted in bit times after EOP
		// A response in the same cycle as the last tick is not a timeout
		case (st_r.ta_state)
			TA_IDLE: begin
				st_nxt.ta_cnt = '0;
				if (eop_in && await_response_in) begin
					st_nxt.ta_state = TA_WAIT;
				end
			end
			TA_WAIT: begin
				if (response_start_in) begin
					st_nxt.ta_state = TA_IDLE;
				end else if (bit_tick_in) begin
					if (st_r.ta_cnt == TA_W'(`TURNAROUND_LIMIT_BITS)) begin
						err_set[`ER_TURNAROUND] = 1'b1;
						st_nxt.ta_state = TA_IDLE;
					end else begin
						st_nxt.ta_cnt = st_r.ta_cnt + 1'b1;
					end
				end
			end
			default: begin
				st_nxt.ta_state = TA_IDLE;
			end
		endcase

		// Error sources
		err_set[`ER_STUFF] = stuff_error_in;
		err_set[`ER_BUS_ADDRESS] = bus_address_error_in;
		err_set[`ER_MEMORY_ACCESS] = memory_access_error_in;
		err_set[`ER_PARTIAL_BYTE] = partial_byte_in;
		err_set[`ER_DATA_CRC] = data_crc_error_in;
		err_set[`ER_PACKET_ID] = packet_id_error_in;
		if (st_r.host_en) begin
			err_set[`ER_CRC5_OR_EOF] = sof_count_zero_in && link_busy_in;
		end else begin
			err_set[`ER_CRC5_OR_EOF] = token_crc_error_in;
		end

		// Write-one-clear; a set in the same cycle wins
		ev_clr = wr_ev ? reg_wr_data_in[7:0] : 8'h00;
		err_clr = wr_err ? reg_wr_data_in[7:0] : 8'h00;
		st_nxt.ev_flag = (st_r.ev_flag & ~ev_clr) | ev_set;
		st_nxt.ev_flag[`EV_TOKEN_DONE] = 1'b0;
		st_nxt.ev_flag[`EV_ERROR_SUMMARY] = 1'b0;
		st_nxt.err_flag = (st_r.err_flag & ~err_clr) | err_set;

		// Status FIFO; a full FIFO drops, so the engine must watch the full output
		// Popping an empty FIFO is ignored, so a stray clear is harmless
		pop = ev_clr[`EV_TOKEN_DONE] && !fifo_empty;
		push = token_done_in && !fifo_full;
		if (push) begin
			st_nxt.fifo[st_r.wr_ptr] = token_status_in;
			st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		end
		st_nxt.fill = st_r.fill + CNT_W'(push) - CNT_W'(pop);

		// Enable and control writes
		if (reg_wr_in && reg_addr_in == `REG_EVENT_ENABLES) begin
			st_nxt.ev_en = reg_wr_data_in[7:0];
		end
		if (reg_wr_in && reg_addr_in == `REG_ERROR_ENABLES) begin
			st_nxt.err_en = reg_wr_data_in[7:0];
		end
		if (reg_wr_in && reg_addr_in == `REG_CONTROL) begin
			st_nxt.host_en = reg_wr_data_in[`CTL_HOST_MODE];
		end

		// Read data stands for one cycle only; unmapped reads give zero
		st_nxt.rd_data = 32'h0000_0000;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`REG_EVENT_FLAGS: st_nxt.rd_data = {24'h00_0000, ev_view};
				`REG_EVENT_ENABLES: st_nxt.rd_data = {24'h00_0000, st_r.ev_en};
				`REG_ERROR_FLAGS: st_nxt.rd_data = {24'h00_0000, st_r.err_flag};
				`REG_ERROR_ENABLES: st_nxt.rd_data = {24'h00_0000, st_r.err_en};
				`REG_XFER_STATUS: begin
					// Head is meaningless when empty, so show zero then
					if (!fifo_empty) begin
						st_nxt.rd_data = {24'h00_0000, head, 2'b00};
					end
				end
				`REG_CONTROL: st_nxt.rd_data = {31'h0000_0000, st_r.host_en};
				default: st_nxt.rd_data = 32'h0000_0000;
			endcase
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '0;
			st_r.ev_flag <= `FLAGS_RESET;
			st_r.err_flag <= `FLAGS_RESET;
			st_r.ev_en <= `ENABLES_RESET;
			st_r.err_en <= `ENABLES_RESET;
			st_r.host_en <= `CONTROL_RESET;
			st_r.ta_state <= TA_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// Outputs
	localparam logic [7:0] SUMMARY_BIT = 8'h01 << `EV_ERROR_SUMMARY;
	logic ev_irq;
	logic err_irq;
	always_comb begin
		// Summary bit leaves the event path and takes its own gate below
		ev_irq = |(ev_view & st_r.ev_en & ~SUMMARY_BIT);
		err_irq = error_summary_flag && st_r.ev_en[`EV_ERROR_SUMMARY];
		module_interrupt_request_out = ev_irq || err_irq;
	end

	assign reg_rd_data_out = st_r.rd_data;
	assign status_fifo_full_out = fifo_full;
	assign host_mode_enable_out = st_r.host_en;

endmodule
`default_nettype wire

// ---- test/usb_flags_sva.sv ----
// Port checks of the USB flag block
`timescale 1ns/100ps
`default_nettype none
module usb_flags_sva (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wr_data_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rd_data_out,
	// Events
	input wire logic stall_handshake_in,
	input wire logic token_done_in,
	input wire logic sof_token_in,
	input wire logic bus_reset_in,
	input wire logic detach_in,
	input wire logic data_crc_error_in,
	// Outputs
	input wire logic status_fifo_full_out,
	input wire logic host_mode_enable_out,
	input wire logic module_interrupt_request_out
);
	// ====
	// Shadow enables and FIFO fill, kept from the register traffic and the token done pulses
	logic [7:0] en_r, ee_r;
	logic [2:0] cnt_r;
	logic pop, push, irq;
	assign irq = module_interrupt_request_out;
	assign pop = reg_wr_in && reg_addr_in == 8'h00 && reg_wr_data_in[3] && cnt_r != 3'h0;
	assign push = token_done_in && cnt_r != 3'h4;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_r <= 8'h00;
			ee_r <= 8'h00;
			cnt_r <= 3'h0;
		end else begin
			if (reg_wr_in && reg_addr_in == 8'h04) en_r <= reg_wr_data_in[7:0];
			if (reg_wr_in && reg_addr_in == 8'h0C) ee_r <= reg_wr_data_in[7:0];
			cnt_r <= cnt_r + 3'(push) - 3'(pop);
		end
	end
	// ====
	// Assertions
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	rd_high_zero_a: assert property ($past(reg_rd_in) |-> reg_rd_data_out[31:8] == 24'h0)
		else $error("read data high bits set");
	rd_quiet_zero_a: assert property (!$past(reg_rd_in) |-> reg_rd_data_out == 32'h0)
		else $error("read data outside read cycle");
	enables_read_a: assert property ($past(reg_rd_in && reg_addr_in == 8'h04) |-> reg_rd_data_out == {24'h0, en_r})
		else $error("event enables read back wrong");
	stall_irq_a: assert property (stall_handshake_in && en_r[7] && !reg_wr_in |=> irq)
		else $error("stall did not raise request");
	irq_masked_a: assert property (en_r == 8'h00 |-> !irq)
		else $error("request with all enables off");
	bus_reset_irq_a: assert property (bus_reset_in && !host_mode_enable_out && en_r[0] && !reg_wr_in |-> ##1 irq)
		else $error("bus reset did not raise request");
	detach_irq_a: assert property (detach_in && host_mode_enable_out && en_r[0] && !reg_wr_in |=> irq)
		else $error("detach did not raise request");
	fifo_full_a: assert property (status_fifo_full_out == (cnt_r == 3'h4))
		else $error("status FIFO full flag wrong");
	crc_irq_a: assert property (data_crc_error_in && ee_r[2] && en_r[1] && !reg_wr_in |=> irq)
		else $error("data CRC error did not raise request");
	sof_irq_a: assert property (sof_token_in && !host_mode_enable_out && en_r[2] && !reg_wr_in |=> irq)
		else $error("frame start did not raise request");
	cover property (status_fifo_full_out && token_done_in);
	cover property (detach_in && host_mode_enable_out);
	cover property (irq && en_r == 8'h02);
endmodule
bind usb_interrupt_error_flags usb_flags_sva chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.reg_addr_in(reg_addr_in), .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rd_data_out(reg_rd_data_out),
	.stall_handshake_in(stall_handshake_in), .token_done_in(token_done_in),
	.sof_token_in(sof_token_in), .bus_reset_in(bus_reset_in), .detach_in(detach_in),
	.data_crc_error_in(data_crc_error_in),
	.status_fifo_full_out(status_fifo_full_out),
	.host_mode_enable_out(host_mode_enable_out),
	.module_interrupt_request_out(module_interrupt_request_out));
`default_nettype wire

// ---- test/usb_line_model.sv ----
// Bus line and bit clock model facing the flag block
`timescale 1ns/100ps
`default_nettype none
module usb_line_model (
	// Clock, reset and bench control
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] line_mode_in,
	// Line state towards the block
	output logic bus_active_out,
	output logic bus_se0_out,
	output logic bus_kstate_out,
	output logic bus_idle_out,
	output logic bit_tick_out
);
	// ====
	// Line state: 0 traffic, 1 quiet J, 2 K, 3 quiet SE0
	logic [3:0] div_r;
	assign bus_active_out = line_mode_in == 2'h0 || line_mode_in == 2'h2;
	assign bus_se0_out = line_mode_in == 2'h3;
	assign bus_kstate_out = line_mode_in == 2'h2;
	assign bus_idle_out = line_mode_in == 2'h1;
	// ====
	// Bit time of 16 cycles, near full speed at this clock
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end
	assign bit_tick_out = div_r == 4'hF;
endmodule
`default_nettype wire

// ---- test/usb_interrupt_error_flags_test.sv ----
// Self-checking bench for the USB flag block
`timescale 1ns/100ps
`default_nettype none
module usb_interrupt_error_flags_test;
	import usb_irq_pkg::*;
	// ====
	// Stimulus and observed signals
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wr_data_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rd_data_out;
	logic [15:0] pk = 16'h0;
	logic await_response_in = 1'b0;
	logic link_busy_in = 1'b0;
	xfer_status_s token_status_in = '0;
	logic [1:0] line_mode = 2'h0;
	logic act, se0, kst, idl, tick;
	logic status_fifo_full_out, host_mode_enable_out, module_interrupt_request_out;
	int errors = 0;
	int samples_checked = 0;
	logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h3C};
	int evb [3] = '{0, 2, 7};
	int erb [7] = '{0, 1, 2, 3, 5, 6, 7};
	usb_line_model line (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .line_mode_in(line_mode),
		.bus_active_out(act), .bus_se0_out(se0), .bus_kstate_out(kst), .bus_idle_out(idl),
		.bit_tick_out(tick));
	usb_interrupt_error_flags #(.IDLE_CYCLES(50)) dut (.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_data_in(reg_wr_data_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rd_data_out(reg_rd_data_out),
		.token_status_in(token_status_in), .await_response_in(await_response_in),
		.link_busy_in(link_busy_in), .status_fifo_full_out(status_fifo_full_out),
		.host_mode_enable_out(host_mode_enable_out),
		.module_interrupt_request_out(module_interrupt_request_out), .bus_active_in(act),
		.bus_se0_in(se0), .bus_kstate_in(kst), .bus_idle_in(idl), .bit_tick_in(tick),
		.bus_reset_in(pk[0]), .detach_in(pk[1]), .sof_token_in(pk[2]), .token_done_in(pk[3]),
		.eop_in(pk[4]), .sof_threshold_in(pk[5]), .response_start_in(pk[6]),
		.stall_handshake_in(pk[7]), .packet_id_error_in(pk[8]), .token_crc_error_in(pk[9]),
		.data_crc_error_in(pk[10]), .partial_byte_in(pk[11]), .sof_count_zero_in(pk[12]),
		.memory_access_error_in(pk[13]), .bus_address_error_in(pk[14]),
		.stuff_error_in(pk[15]));
	initial forever #2.5 sys_clk_in = ~sys_clk_in;
	// ====
	// Bus and compare tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wr_data_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rd_data_out, exp);
		@(posedge sys_clk_in);
	endtask
	task automatic pulse(input int n);
		pk[n] <= 1'b1;
		@(posedge sys_clk_in);
		pk[n] <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic irq(input logic exp);
		#1 chk({31'h0, module_interrupt_request_out}, {31'h0, exp});
		@(posedge sys_clk_in);
	endtask
	// ====
	// Scenarios
	task automatic t_regs();
		foreach (regs[i]) rd(regs[i], 32'h0);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04, 32'hFF);
		wr(8'h0C, 32'hFFFFFFFF);
		rd(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		$display("registers done");
	endtask
	task automatic t_events();
		wr(8'h04, 32'h85);
		foreach (evb[i]) begin
			pulse(evb[i]);
			irq(1'b1);
			rd(8'h00, 32'h1 << evb[i]);
			wr(8'h00, 32'h1 << evb[i]);
			rd(8'h00, 32'h0);
		end
		pulse(1);
		pulse(5);
		rd(8'h00, 32'h0);
		$display("events done");
	endtask
	task automatic t_errors();
		wr(8'h04, 32'h02);
		foreach (erb[i]) begin
			wr(8'h0C, 32'hFF ^ (32'h1 << erb[i]));
			pulse(erb[i] + 8);
			rd(8'h08, 32'h1 << erb[i]);
			rd(8'h00, 32'h0);
			irq(1'b0);
			wr(8'h0C, 32'hFF);
			rd(8'h00, 32'h2);
			irq(1'b1);
			wr(8'h08, 32'h1 << erb[i]);
			rd(8'h00, 32'h0);
		end
		pulse(10);
		irq(1'b1);
		wr(8'h00, 32'h2);
		rd(8'h00, 32'h2);
		wr(8'h08, 32'h4);
		wr(8'h04, 32'h0);
		$display("errors done");
	endtask
	task automatic t_fifo();
		for (int k = 0; k < 5; k++) begin
			token_status_in <= 6'(k * 11 + 5);
			pulse(3);
		end
		#1 chk({31'h0, status_fifo_full_out}, 32'h1);
		@(posedge sys_clk_in);
		for (int k = 0; k < 4; k++) begin
			rd(8'h00, 32'h08);
			rd(8'h10, 32'((k * 11 + 5) << 2));
			wr(8'h00, 32'h08);
		end
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		$display("status FIFO done");
	endtask
	task automatic t_host();
		wr(8'h14, 32'h1);
		#1 chk({31'h0, host_mode_enable_out}, 32'h1);
		@(posedge sys_clk_in);
		wr(8'h04, 32'h01);
		pulse(1);
		irq(1'b1);
		wr(8'h00, 32'h1);
		pulse(0);
		pulse(2);
		rd(8'h00, 32'h0);
		pulse(5);
		rd(8'h00, 32'h4);
		wr(8'h00, 32'h4);
		pulse(9);
		pulse(12);
		rd(8'h08, 32'h0);
		link_busy_in <= 1'b1;
		pulse(12);
		link_busy_in <= 1'b0;
		rd(8'h08, 32'h2);
		wr(8'h08, 32'h2);
		line_mode <= 2'h3;
		repeat (505) @(posedge sys_clk_in);
		rd(8'h00, 32'h0);
		line_mode <= 2'h1;
		repeat (505) @(posedge sys_clk_in);
		rd(8'h00, 32'h50);
		wr(8'h00, 32'h50);
		line_mode <= 2'h0;
		wr(8'h14, 32'h0);
		#1 chk({31'h0, host_mode_enable_out}, 32'h0);
		@(posedge sys_clk_in);
		wr(8'h04, 32'h0);
		$display("host mode done");
	endtask
	task automatic t_line();
		// Resume enable stays off here, the bus is not suspended
		line_mode <= 2'h2;
		repeat (505) @(posedge sys_clk_in);
		rd(8'h00, 32'h20);
		wr(8'h00, 32'h20);
		line_mode <= 2'h0;
		await_response_in <= 1'b1;
		pulse(4);
		await_response_in <= 1'b0;
		repeat (240) @(posedge sys_clk_in);
		rd(8'h08, 32'h0);
		repeat (48) @(posedge sys_clk_in);
		rd(8'h08, 32'h10);
		wr(8'h08, 32'h10);
		await_response_in <= 1'b1;
		pulse(4);
		await_response_in <= 1'b0;
		pulse(6);
		pulse(4);
		repeat (320) @(posedge sys_clk_in);
		rd(8'h08, 32'h0);
		$display("line timers done");
	endtask
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ====
	// Main sequence and watchdog
	initial begin
		repeat (8) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		@(posedge sys_clk_in);
		t_regs();
		t_events();
		t_errors();
		t_fifo();
		t_host();
		t_line();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
